// >>> hdl/sfd_pkg.sv
package sfd_pkg;

  // ****************************************
  // frame layout
  // ****************************************
  localparam int FRAME_W = 16;
  localparam int BIT_RW = 15;
  localparam int BIT_TS = 14;
  localparam int ADDR_HI = 13;
  localparam int ADDR_LO = 9;
  localparam int BIT_PAR = 8;
  localparam logic [4:0] BITS_PER_FRAME = 5'h10;
  localparam logic [4:0] HDR_LAST_BIT = 5'h07;

  // ****************************************
  // main register map
  // ****************************************
  localparam logic [4:0] ADR_STARTUP_REGULATOR_CFG_1 = 5'h01;
  localparam logic [4:0] ADR_STARTUP_INTERRUPT_CFG = 5'h06;
  localparam logic [4:0] ADR_HARDWARE_CONFIGURATION = 5'h08;
  localparam logic [4:0] ADR_WAKE_ORIGIN = 5'h09;
  localparam logic [4:0] ADR_PIN_INPUT_LEVELS = 5'h0B;
  localparam logic [4:0] ADR_SUPPLY_STATE_1 = 5'h0C;
  localparam logic [4:0] ADR_TRANSCEIVER_DIAGNOSIS_2 = 5'h12;
  localparam logic [4:0] ADR_SERIAL_LINK_DIAGNOSIS = 5'h13;
  localparam int NUM_CFG = 6;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] FLAGS_RST = 8'h00;

  // global flag positions in response bits 15:8
  localparam int FLG_SPI = 7;
  localparam int FLG_WAKE = 6;
  localparam int FLG_CAN = 5;
  localparam int FLG_PIN = 3;
  localparam int FLG_PRE = 2;
  localparam int FLG_CORE = 1;
  localparam int FLG_OTH = 0;

  // ****************************************
  // controller registers
  // ****************************************
  localparam logic [3:0] HREG_CMD = 4'h0;
  localparam logic [3:0] HREG_RESP = 4'h1;
  localparam logic [3:0] HREG_STAT = 4'h2;

  // ****************************************
  // link timing
  // ****************************************
  localparam int SYS_PERIOD_NS = 20;
  localparam int SCLK_PERIOD_NS = 160;
  localparam int HALF_CYC = SCLK_PERIOD_NS / (2 * SYS_PERIOD_NS);
  localparam int GAP_CYC = 2 * HALF_CYC;

  typedef enum logic [2:0] {
    HST_IDLE = 3'b000,
    HST_LEAD = 3'b001,
    HST_HIGH = 3'b011,
    HST_LOW = 3'b010,
    HST_TRAIL = 3'b110,
    HST_GAP = 3'b111
  } sfd_hstate_t;

  // parity over bits 15:9 and 7:0, one when the count of ones is even
  function automatic logic sfd_par(input logic [15:0] f);
    sfd_par = ~(^{f[15:9], f[7:0]});
  endfunction : sfd_par

endpackage : sfd_pkg

// >>> hdl/sfd_link_if.sv
`timescale 1ns/1ps
interface sfd_link_if;
  logic sclk;
  logic cs_n;
  logic mosi;
  logic miso;
  logic miso_oe;
  logic miso_line;

  // undriven data line reads low
  assign miso_line = miso_oe ? miso : 1'b0;

  modport dev (input sclk, input cs_n, input mosi, output miso, output miso_oe);
  modport host (output sclk, output cs_n, output mosi, input miso_line);
endinterface : sfd_link_if

// >>> hdl/sfd_sync.sv
`timescale 1ns/1ps
module sfd_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // data
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      meta_r <= RST_VAL;
      q <= RST_VAL;
    end else begin
      meta_r <= d;
      q <= meta_r;
    end
  end
endmodule : sfd_sync

// >>> hdl/sfd_dev.sv
`timescale 1ns/1ps
module sfd_dev (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link
  sfd_link_if.dev link,
  // device state
  input wire logic init_phase,
  input wire logic [7:0] wake_src,
  input wire logic can_diag,
  input wire logic [7:0] pin_in,
  input wire logic pre_evt,
  input wire logic core_evt,
  input wire logic oth_evt,
  input wire logic [7:0] hw_cfg_in,
  input wire logic [7:0][7:0] supply_diag_in,
  // configuration and flags
  output logic [5:0][7:0] cfg_out,
  output logic [7:0] flags_out,
  output logic [7:0] link_diag_out,
  // fail-safe space writes
  output logic fs_wr_stb,
  output logic [4:0] fs_addr,
  output logic [7:0] fs_data
);

  // ****************************************
  // pin synchronisation and edges
  // ****************************************
  logic [2:0] pins_s;
  logic sclk_s, cs_s, mosi_s;
  logic sclk_p_r, cs_p_r;
  logic sclk_rise, sclk_fall, cs_fall, cs_rise, active;

  sfd_sync #(.W(3), .RST_VAL(3'b010)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d({link.sclk, link.cs_n, link.mosi}),
    .q(pins_s)
  );

  assign sclk_s = pins_s[2];
  assign cs_s = pins_s[1];
  assign mosi_s = pins_s[0];
  assign active = ~cs_s;
  assign sclk_rise = sclk_s & ~sclk_p_r;
  assign sclk_fall = ~sclk_s & sclk_p_r;
  assign cs_fall = ~cs_s & cs_p_r;
  assign cs_rise = cs_s & ~cs_p_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_p_r <= 1'b0;
      cs_p_r <= 1'b1;
    end else begin
      sclk_p_r <= sclk_s;
      cs_p_r <= cs_s;
    end
  end

  // ****************************************
  // receive shift and bit count
  // ****************************************
  logic [15:0] rx_r, rx_nxt;
  logic [4:0] cnt_r, cnt_nxt;
  logic take_bit;

  assign take_bit = active & sclk_rise & ~cs_fall;
  assign rx_nxt = take_bit ? {rx_r[14:0], mosi_s} : rx_r;
  assign cnt_nxt = cs_fall ? 5'h00 :
                   (take_bit && cnt_r != 5'h1F) ? cnt_r + 5'h01 : cnt_r;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rx_r <= 16'h0000;
      cnt_r <= 5'h00;
    end else begin
      rx_r <= rx_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ****************************************
  // register read selection
  // ****************************************
  logic [7:0] flags_r, flags_nxt;
  logic [7:0] diag_r, diag_nxt;
  logic [7:0] cfg_r [sfd_pkg::NUM_CFG];

  function automatic logic is_cfg(input logic [4:0] a);
    is_cfg = (a >= sfd_pkg::ADR_STARTUP_REGULATOR_CFG_1) &&
             (a <= sfd_pkg::ADR_STARTUP_INTERRUPT_CFG);
  endfunction : is_cfg

  function automatic logic [7:0] rd_mux(input logic [4:0] a);
    logic [4:0] s;
    s = a - sfd_pkg::ADR_SUPPLY_STATE_1;
    rd_mux = 8'h00;
    if (is_cfg(a)) begin
      rd_mux = cfg_r[3'(a - sfd_pkg::ADR_STARTUP_REGULATOR_CFG_1)];
    end else if (a == sfd_pkg::ADR_HARDWARE_CONFIGURATION) begin
      rd_mux = hw_cfg_in;
    end else if (a == sfd_pkg::ADR_WAKE_ORIGIN) begin
      rd_mux = wake_src;
    end else if (a == sfd_pkg::ADR_PIN_INPUT_LEVELS) begin
      rd_mux = pin_in;
    end else if (a >= sfd_pkg::ADR_SUPPLY_STATE_1 &&
                 a <= sfd_pkg::ADR_TRANSCEIVER_DIAGNOSIS_2) begin
      rd_mux = supply_diag_in[s[2:0]];
    end else if (a == sfd_pkg::ADR_SERIAL_LINK_DIAGNOSIS) begin
      rd_mux = diag_r;
    end
  endfunction : rd_mux

  // header complete: rx_nxt[7:0] holds bits 15:8 of the frame
  logic hdr_done, hdr_rw, hdr_ts;
  logic [4:0] hdr_addr;
  logic [7:0] lo_sel;

  assign hdr_done = take_bit && cnt_r == sfd_pkg::HDR_LAST_BIT;
  assign hdr_rw = rx_nxt[7];
  assign hdr_ts = rx_nxt[6];
  assign hdr_addr = rx_nxt[5:1];
  // a process, so that the selection follows every register the function reads
  always_comb begin
    lo_sel = hdr_rw ? diag_r : (hdr_ts ? 8'h00 : rd_mux(hdr_addr));
  end

  // ****************************************
  // response shift
  // ****************************************
  logic [7:0] hi_r, lo_r;
  logic miso_r;
  logic miso_bit;
  logic [2:0] out_idx;

  assign out_idx = ~cnt_r[2:0];
  assign miso_bit = cnt_r[3] ? lo_r[out_idx] : hi_r[out_idx];

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      hi_r <= 8'h00;
      lo_r <= 8'h00;
      miso_r <= 1'b0;
    end else begin
      if (cs_fall) begin
        hi_r <= flags_r;
        miso_r <= flags_r[7];
      end else if (active && sclk_fall && cnt_r != 5'h00 && !cnt_r[4]) begin
        miso_r <= miso_bit;
      end
      if (hdr_done) begin
        lo_r <= lo_sel;
      end
    end
  end

  assign link.miso = miso_r;
  assign link.miso_oe = active;

  // ****************************************
  // frame end decode
  // ****************************************
  logic f_wr, f_ts, len_ok, par_ok, cfg_ok, bad, wr_cfg, wr_fs, rd_ok;
  logic [4:0] f_addr;

  assign f_wr = rx_r[sfd_pkg::BIT_RW];
  assign f_ts = rx_r[sfd_pkg::BIT_TS];
  assign f_addr = rx_r[sfd_pkg::ADDR_HI:sfd_pkg::ADDR_LO];
  assign len_ok = cnt_r == sfd_pkg::BITS_PER_FRAME;
  assign par_ok = rx_r[sfd_pkg::BIT_PAR] == sfd_pkg::sfd_par(rx_r);
  assign cfg_ok = is_cfg(f_addr) & init_phase;
  assign bad = ~len_ok | (f_wr & (~par_ok | (~f_ts & ~cfg_ok)));
  assign wr_cfg = cs_rise & ~bad & f_wr & ~f_ts;
  assign wr_fs = cs_rise & ~bad & f_wr & f_ts;
  assign rd_ok = cs_rise & ~bad;

  assign diag_nxt = cs_rise ?
    {5'h00, f_wr & ~f_ts & ~cfg_ok, f_wr & ~par_ok, ~len_ok} : diag_r;

  // ****************************************
  // global flags
  // ****************************************
  logic [7:0] pin_p_r;
  logic [7:0] ev;

  assign ev[sfd_pkg::FLG_SPI] = cs_rise & bad;
  assign ev[sfd_pkg::FLG_WAKE] = |wake_src;
  assign ev[sfd_pkg::FLG_CAN] = can_diag;
  assign ev[4] = 1'b0;
  assign ev[sfd_pkg::FLG_PIN] = pin_in != pin_p_r;
  assign ev[sfd_pkg::FLG_PRE] = pre_evt;
  assign ev[sfd_pkg::FLG_CORE] = core_evt;
  assign ev[sfd_pkg::FLG_OTH] = oth_evt;

  // reported flags drop after a good frame unless the source persists
  assign flags_nxt = (flags_r & ~(rd_ok ? hi_r : 8'h00)) | ev;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      flags_r <= sfd_pkg::FLAGS_RST;
      diag_r <= 8'h00;
      pin_p_r <= 8'h00;
      fs_wr_stb <= 1'b0;
      fs_addr <= 5'h00;
      fs_data <= 8'h00;
    end else begin
      flags_r <= flags_nxt;
      diag_r <= diag_nxt;
      pin_p_r <= pin_in;
      fs_wr_stb <= wr_fs;
      if (wr_fs) begin
        fs_addr <= f_addr;
        fs_data <= rx_r[7:0];
      end
    end
  end

  // ****************************************
  // startup configuration registers
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < sfd_pkg::NUM_CFG; i++) begin
        cfg_r[i] <= sfd_pkg::CFG_RST;
      end
    end else if (wr_cfg) begin
      cfg_r[3'(f_addr - sfd_pkg::ADR_STARTUP_REGULATOR_CFG_1)] <= rx_r[7:0];
    end
  end

  always_comb begin
    for (int i = 0; i < sfd_pkg::NUM_CFG; i++) begin
      cfg_out[i] = cfg_r[i];
    end
  end

  assign flags_out = flags_r;
  assign link_diag_out = diag_r;

endmodule : sfd_dev

// >>> hdl/sfd_host.sv
`timescale 1ns/1ps
module sfd_host (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link
  sfd_link_if.host link,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata
);

  // ****************************************
  // frame build
  // ****************************************
  logic [15:0] cmd_raw, cmd_frame;
  logic start;

  assign cmd_raw = {reg_wdata[15:9], 1'b0, reg_wdata[15] ? reg_wdata[7:0] : 8'h00};
  assign cmd_frame = {cmd_raw[15:9],
                      reg_wdata[15] & sfd_pkg::sfd_par(cmd_raw),
                      cmd_raw[7:0]};

  // ****************************************
  // link sequencer
  // ****************************************
  sfd_pkg::sfd_hstate_t st_r, st_nxt;
  logic [15:0] tx_r, rx_r, cmd_r;
  logic [3:0] bit_r;
  logic [7:0] tmr_r;
  logic sclk_r, cs_n_r, mosi_r, done_r;
  logic miso_s, tmo, busy, last;

  sfd_sync #(.W(1), .RST_VAL(1'b0)) u_sync (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .d(link.miso_line),
    .q(miso_s)
  );

  assign busy = st_r != sfd_pkg::HST_IDLE;
  assign start = reg_wr && reg_addr == sfd_pkg::HREG_CMD && !busy;
  assign tmo = tmr_r == 8'h00;
  assign last = bit_r == 4'hF;

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      sfd_pkg::HST_IDLE: if (start) st_nxt = sfd_pkg::HST_LEAD;
      sfd_pkg::HST_LEAD: if (tmo) st_nxt = sfd_pkg::HST_HIGH;
      sfd_pkg::HST_HIGH: if (tmo) st_nxt = last ? sfd_pkg::HST_TRAIL : sfd_pkg::HST_LOW;
      sfd_pkg::HST_LOW: if (tmo) st_nxt = sfd_pkg::HST_HIGH;
      sfd_pkg::HST_TRAIL: if (tmo) st_nxt = sfd_pkg::HST_GAP;
      sfd_pkg::HST_GAP: if (tmo) st_nxt = sfd_pkg::HST_IDLE;
      default: st_nxt = sfd_pkg::HST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_r <= sfd_pkg::HST_IDLE;
      tmr_r <= 8'h00;
    end else begin
      st_r <= st_nxt;
      if (st_nxt != st_r) begin
        tmr_r <= (st_nxt == sfd_pkg::HST_GAP) ? 8'(sfd_pkg::GAP_CYC - 1) :
                                                8'(sfd_pkg::HALF_CYC - 1);
      end else if (!tmo) begin
        tmr_r <= tmr_r - 8'h01;
      end
    end
  end

  // miso is sampled at the end of each high phase, well after the device moved it
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      tx_r <= 16'h0000;
      rx_r <= 16'h0000;
      cmd_r <= 16'h0000;
      bit_r <= 4'h0;
      sclk_r <= 1'b0;
      cs_n_r <= 1'b1;
      mosi_r <= 1'b0;
      done_r <= 1'b0;
    end else begin
      if (start) begin
        cmd_r <= cmd_frame;
        tx_r <= {cmd_frame[14:0], 1'b0};
        mosi_r <= cmd_frame[15];
        cs_n_r <= 1'b0;
        bit_r <= 4'h0;
      end
      if (st_r == sfd_pkg::HST_LEAD && tmo) begin
        sclk_r <= 1'b1;
      end
      if (st_r == sfd_pkg::HST_LOW && tmo) begin
        sclk_r <= 1'b1;
      end
      if (st_r == sfd_pkg::HST_HIGH && tmo) begin
        sclk_r <= 1'b0;
        rx_r <= {rx_r[14:0], miso_s};
        bit_r <= bit_r + 4'h1;
        if (!last) begin
          mosi_r <= tx_r[15];
          tx_r <= {tx_r[14:0], 1'b0};
        end
      end
      if (st_r == sfd_pkg::HST_TRAIL && tmo) begin
        cs_n_r <= 1'b1;
      end
      // completion wins over a same-cycle clear
      if (st_r == sfd_pkg::HST_GAP && tmo) begin
        done_r <= 1'b1;
      end else if (reg_rd && reg_addr == sfd_pkg::HREG_RESP) begin
        done_r <= 1'b0;
      end
    end
  end

  assign link.sclk = sclk_r;
  assign link.cs_n = cs_n_r;
  assign link.mosi = mosi_r;

  // ****************************************
  // register read port
  // ****************************************
  logic [15:0] rd_sel;

  assign rd_sel = (reg_addr == sfd_pkg::HREG_CMD) ? cmd_r :
                  (reg_addr == sfd_pkg::HREG_RESP) ? rx_r :
                  (reg_addr == sfd_pkg::HREG_STAT) ? {14'h0000, done_r, busy} : 16'h0000;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      reg_rdata <= rd_sel;
    end else begin
      reg_rdata <= 16'h0000;
    end
  end

endmodule : sfd_host

// >>> tb/sfd_link_sva.sv
`timescale 1ns/1ps
module sfd_link_sva (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // serial link
  input wire logic sclk,
  input wire logic cs_n,
  input wire logic mosi,
  input wire logic miso_oe
);
  // ****
  // frame capture
  // ****
  logic sclk_r;
  logic [4:0] cnt_r;
  logic [15:0] sh_r;
  wire sclk_rise = sclk & ~sclk_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sclk_r <= 1'b0;
      cnt_r <= 5'h00;
      sh_r <= 16'h0000;
    end else begin
      sclk_r <= sclk;
      if (cs_n) begin
        cnt_r <= 5'h00;
      end else if (sclk_rise) begin
        cnt_r <= cnt_r + 5'h01;
        sh_r <= {sh_r[14:0], mosi};
      end
    end
  end
  // ****
  // properties
  // ****
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_n);
  property p_idle; cs_n |-> !sclk; endproperty
  a_idle: assert property (p_idle)
    else $error("serial clock high outside a frame");
  property p_count; $rose(cs_n) |-> cnt_r == 5'h10; endproperty
  a_count: assert property (p_count)
    else $error("frame not sixteen clocks long");
  property p_rdzero; $rose(cs_n) && !sh_r[15] |-> sh_r[8:0] == 9'h000; endproperty
  a_rdzero: assert property (p_rdzero)
    else $error("read frame parity or data not zero");
  property p_par; $rose(cs_n) && sh_r[15] |-> sh_r[8] == ~^{sh_r[15:9], sh_r[7:0]};
  endproperty
  a_par: assert property (p_par)
    else $error("write frame parity wrong");
  property p_hold; $rose(sclk) |=> $stable(mosi) [*3]; endproperty
  a_hold: assert property (p_hold)
    else $error("host data moved while clock high");
  property p_high; $rose(sclk) |-> sclk [*4] ##1 !sclk; endproperty
  a_high: assert property (p_high)
    else $error("clock high phase not four cycles");
  property p_gap; $rose(cs_n) |-> cs_n [*8]; endproperty
  a_gap: assert property (p_gap)
    else $error("select gap too short");
  property p_oe_on; $fell(cs_n) |-> ##[1:6] miso_oe; endproperty
  a_oe_on: assert property (p_oe_on)
    else $error("device did not drive its data line");
  property p_oe_off; $rose(cs_n) |-> ##[0:6] !miso_oe; endproperty
  a_oe_off: assert property (p_oe_off)
    else $error("device kept driving after frame");
endmodule : sfd_link_sva

// >>> tb/spi_frame_decode_main_map_bench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin errors++; \
  $display("[ERR] %0t mismatch", $time); end end
module spi_frame_decode_main_map_bench;
  logic clk_sys, rst_n, init_phase, can_diag, pre_evt, core_evt, oth_evt, fs_wr_stb;
  logic [7:0] wake_src, pin_in, hw_cfg_in, flags_out, link_diag_out, flags2, diag2;
  logic [7:0] fs_data, fs_d, p, w, d;
  logic [7:0][7:0] supply_diag_in;
  logic [5:0][7:0] cfg_out, cfg2;
  logic [7:0] cfgx [6];
  logic [4:0] fs_addr, fs_a, a5;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, r, f;
  logic reg_wr, reg_rd;
  int errors, n_checks, fs_cnt, i;
  logic [4:0] unused [4] = '{5'h00, 5'h07, 5'h0A, 5'h14};
  sfd_link_if link();
  sfd_link_if link2();
  sfd_host sfd_host_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
  sfd_dev sfd_dev_inst (.clk_sys(clk_sys), .rst_n(rst_n), .link(link), .init_phase(init_phase),
    .wake_src(wake_src), .can_diag(can_diag), .pin_in(pin_in), .pre_evt(pre_evt),
    .core_evt(core_evt), .oth_evt(oth_evt), .hw_cfg_in(hw_cfg_in),
    .supply_diag_in(supply_diag_in), .cfg_out(cfg_out), .flags_out(flags_out),
    .link_diag_out(link_diag_out), .fs_wr_stb(fs_wr_stb), .fs_addr(fs_addr), .fs_data(fs_data));
  sfd_dev sfd_dev_inst2 (.clk_sys(clk_sys), .rst_n(rst_n), .link(link2), .init_phase(init_phase),
    .wake_src(wake_src), .can_diag(can_diag), .pin_in(pin_in), .pre_evt(pre_evt),
    .core_evt(core_evt), .oth_evt(oth_evt), .hw_cfg_in(hw_cfg_in),
    .supply_diag_in(supply_diag_in), .cfg_out(cfg2), .flags_out(flags2),
    .link_diag_out(diag2), .fs_wr_stb(), .fs_addr(), .fs_data());
  sfd_link_sva sfd_link_sva_inst (.clk_sys(clk_sys), .rst_n(rst_n), .sclk(link.sclk),
    .cs_n(link.cs_n), .mosi(link.mosi), .miso_oe(link.miso_oe));
  // ****
  // helpers
  // ****
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys) begin
    if (fs_wr_stb === 1'b1) begin
      fs_cnt++;
      fs_a = fs_addr;
      fs_d = fs_data;
    end
  end
  function automatic logic [15:0] expf(input logic [15:0] c);
    expf = c[15] ? {c[15:9], ~^{c[15:9], c[7:0]}, c[7:0]} : {c[15:9], 9'h000};
  endfunction : expf
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  task automatic wr(input logic [3:0] a, input logic [15:0] dat);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_wdata <= dat;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a, output logic [15:0] q);
    @(posedge clk_sys);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    #1 q = reg_rdata;
  endtask : rd
  task automatic frame(input logic [15:0] c, output logic [15:0] rsp);
    logic [15:0] st;
    int k;
    wr(sfd_pkg::HREG_CMD, c);
    for (k = 0; k < 400; k++) begin
      rd(sfd_pkg::HREG_STAT, st);
      if (st[1] === 1'b1) break;
    end
    `CHK(k < 400, 1'b1)
    rd(sfd_pkg::HREG_CMD, st);
    `CHK(st, expf(c))
    rd(sfd_pkg::HREG_RESP, rsp);
  endtask : frame
  // bit-banged host on the second link, may break the frame on purpose
  task automatic bb(input logic [15:0] c, input int n);
    @(posedge clk_sys);
    link2.cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int k = 0; k < n; k++) begin
      link2.mosi <= c[15 - k];
      repeat (4) @(posedge clk_sys);
      link2.sclk <= 1'b1;
      repeat (4) @(posedge clk_sys);
      link2.sclk <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    link2.cs_n <= 1'b1;
    repeat (12) @(posedge clk_sys);
  endtask : bb
  // ****
  // tests
  // ****
  initial begin
    #400000;
    errors++;
    complete_run();
  end
  initial begin
    void'($urandom(32'hFD5AA899));
    {rst_n, init_phase, can_diag, pre_evt, core_evt, oth_evt, reg_wr, reg_rd} = 8'h00;
    {wake_src, pin_in, hw_cfg_in, supply_diag_in} = '0;
    {reg_addr, reg_wdata} = '0;
    {link2.sclk, link2.cs_n, link2.mosi} = 3'h2;
    repeat (3) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    `CHK(flags_out, 8'h00)
    p = 8'($urandom_range(255, 1));
    w = 8'($urandom_range(255, 1));
    {can_diag, pre_evt, core_evt, oth_evt} <= 4'hF;
    {wake_src, pin_in, hw_cfg_in} <= {w, p, 8'($urandom)};
    for (i = 0; i < 8; i++) supply_diag_in[i] <= 8'($urandom);
    repeat (2) @(posedge clk_sys);
    {can_diag, pre_evt, core_evt, oth_evt, wake_src} <= 12'h000;
    repeat (8) @(posedge clk_sys);
    `CHK(flags_out, 8'h6F)
    frame({7'h08, 9'h000}, r);
    `CHK(r, {8'h6F, hw_cfg_in})
    `CHK(flags_out, 8'h00)
    frame({7'h0B, 9'h100}, r);
    `CHK(r, {8'h00, p})
    wake_src <= w;
    repeat (6) @(posedge clk_sys);
    frame({2'h0, 5'h09, 9'h000}, r);
    `CHK(r, {8'h40, w})
    `CHK(flags_out[6], 1'b1)
    wake_src <= 8'h00;
    for (i = 0; i < 4; i++) begin
      frame({2'h0, unused[i], 9'h000}, r);
      `CHK(r, {(i == 0) ? 8'h40 : 8'h00, 8'h00})
    end
    frame({2'h1, 5'h01, 9'h000}, r);
    `CHK(r, 16'h0000)
    init_phase <= 1'b1;
    for (i = 1; i < 7; i++) begin
      cfgx[i - 1] = 8'($urandom);
      frame({2'h2, 5'(i), 1'b0, cfgx[i - 1]}, r);
      `CHK(r, 16'h0000)
      `CHK(cfg_out[i - 1], cfgx[i - 1])
    end
    for (i = 1; i < 7; i++) begin
      frame({2'h0, 5'(i), 9'h000}, r);
      `CHK(r[7:0], cfgx[i - 1])
    end
    init_phase <= 1'b0;
    frame({2'h2, 5'h03, 1'b0, ~cfgx[2]}, r);
    `CHK(cfg_out[2], cfgx[2])
    `CHK(flags_out[7], 1'b1)
    `CHK(link_diag_out, 8'h04)
    frame({2'h0, 5'h13, 9'h000}, r);
    `CHK(r, {8'h80, 8'h04})
    init_phase <= 1'b1;
    frame({2'h2, 5'h08, 9'h0A5}, r);
    `CHK(flags_out[7], 1'b1)
    for (i = 0; i < 7; i++) begin
      frame({2'h0, 5'h0C + 5'(i), 9'h000}, r);
      `CHK(r[7:0], supply_diag_in[i])
    end
    a5 = 5'($urandom);
    d = 8'($urandom);
    frame({2'h3, a5, 1'b0, d}, r);
    `CHK({fs_cnt == 1, fs_a, fs_d}, {1'b1, a5, d})
    f = {2'h2, 5'h01, 1'b0, 8'h5A};
    bb({f[15:9], ^{f[15:9], f[7:0]}, f[7:0]}, 16);
    `CHK({cfg2[0], diag2[1], flags2[7]}, {8'h00, 2'h3})
    bb(expf(f), 15);
    `CHK({cfg2[0], diag2[0]}, {8'h00, 1'b1})
    bb(expf(f), 16);
    `CHK(cfg2[0], 8'h5A)
    complete_run();
  end
endmodule : spi_frame_decode_main_map_bench
